// ===== rtl/bridge_cmd_consts.vh
// constants for the bridge command register block
`ifndef BRIDGE_CMD_CONSTS_VH
`define BRIDGE_CMD_CONSTS_VH

// ==========================================================
// register map (byte offsets on the configuration port)
`define CMD_OFFSET 8'h04
`define ACT_OFFSET 8'h80

// ==========================================================
// reset values and masks
`define CMD_RESET 16'h0000
`define CMD_WR_MASK 16'h0107
`define ACT_RESET 16'h0000
`define RD_ZERO 16'h0000
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01

// ==========================================================
// command register bit positions
`define BIT_IO_EN 0
`define BIT_MEM_EN 1
`define BIT_BM_EN 2
`define BIT_SPECIAL 3
`define BIT_MWI 4
`define BIT_PERR 6
`define BIT_STEP 7
`define BIT_SERR 8
`define BIT_FAST_B2B_ENABLE 9

// ==========================================================
// window field to address mapping
`define MEM_ADDR_HI 31
`define MEM_ADDR_LO 20
`define WIN_FIELD_HI 15
`define WIN_FIELD_LO 4
`define IO_ADDR_HI 15
`define IO_ADDR_LO 12
`define IO_FIELD_HI 7
`define IO_FIELD_LO 4

// ==========================================================
// activity register layout
`define ACT_ABORT_HI 7
`define ACT_ABORT_LO 0
`define ACT_SERR_HI 15
`define ACT_SERR_LO 8

`endif

// ===== rtl/bridge_command_register.v
// command register of the virtual bridge function with its decode gating
//
// Functional notes
// R1 - 16-bit mixed register, resets to zero
// R2 - bit 9 reads zero, ignores writes
// R3 - bit 8 enables system-error messaging
// R4 - bit 8 clear: no error message
// R5 - bit 8 set: enabled errors messaged, recorded
// R6 - bit 7 reads zero, ignores writes
// R7 - bit 6 reads zero, no parity
// R8 - bit 4 read-only, returns zero
// R9 - bit 3 reads zero, ignores writes
// R10 - bit 2 clear: master cycles aborted
// R11 - bit 2 set: accept in-range master cycles
// R12 - sideband and pipe requests ignore bit 2
// R13 - bit 1 clear: no memory decode
// R14 - bit 1 set: both memory windows decode
// R15 - bit 0 clear: no I/O decode
// R16 - software sets bit 0 before I/O
// R17 - reserved bits read zero, ignore writes
//
// The implementer's own choice: strobed register access.
`include "bridge_cmd_consts.vh"
module bridge_command_register #(
	parameter NERR = 4
) (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// configuration port
	input wire [7:0] cfg_addr,
	input wire [15:0] cfg_wdata,
	input wire cfg_wr,
	input wire cfg_rd,
	output reg [15:0] cfg_rdata,
	// window bounds from the partner registers
	input wire [15:0] memory_window_base,
	input wire [15:0] memory_window_limit,
	input wire [15:0] prefetch_window_base,
	input wire [15:0] prefetch_window_limit,
	input wire [7:0] io_window_base,
	input wire [7:0] io_window_limit,
	// error reporting
	input wire [NERR-1:0] bridge_control_reg,
	input wire [NERR-1:0] err_condition,
	input wire hub_link_ready,
	output reg hub_link_serr_msg,
	output reg sys_err_signaled,
	// primary-side cycles aimed at the bridge
	input wire host_req_valid,
	input wire [31:0] host_req_addr,
	input wire host_req_is_io,
	output reg host_mem_claim,
	output reg host_io_claim,
	// secondary-side master cycles
	input wire frame_req_valid,
	input wire frame_req_in_range,
	output reg frame_accept,
	output reg frame_master_abort,
	// sideband and pipe requests
	input wire sba_req_valid,
	output reg sba_accept,
	// command bits for the rest of the bridge
	output reg bus_master_enable,
	output reg memory_access_enable,
	output reg io_access_enable,
	output reg sys_err_msg_enable
);

	// ==========================================================
	// register storage
	reg [15:0] bridge_command_reg;
	reg [15:0] bridge_command_next;
	reg [7:0] abort_count_reg;
	reg [7:0] abort_count_next;
	reg [7:0] serr_count_reg;
	reg [7:0] serr_count_next;
	reg [15:0] rdata_next;

	wire cmd_sel = (cfg_addr == `CMD_OFFSET);
	wire act_sel = (cfg_addr == `ACT_OFFSET);

	// only the four writable bits are stored; every hardwired and reserved
	// bit is forced to zero so no write can ever reach it
	always @* begin
		bridge_command_next = bridge_command_reg;
		if (cfg_wr && cmd_sel) begin
			bridge_command_next = cfg_wdata & `CMD_WR_MASK; // R2 R6 R7 R8 R9 R17
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			bridge_command_reg <= `CMD_RESET; // R1
		end else begin
			bridge_command_reg <= bridge_command_next; // R1
		end
	end

	// ==========================================================
	// decoded command bits
	wire io_en = bridge_command_reg[`BIT_IO_EN];
	wire mem_en = bridge_command_reg[`BIT_MEM_EN];
	wire bm_en = bridge_command_reg[`BIT_BM_EN];
	wire serr_en = bridge_command_reg[`BIT_SERR];

	// ==========================================================
	// primary-side window decode
	wire mem_hit;
	wire pref_hit;
	wire io_hit;

	window_range_match #(
		.W(12)
	) u_mem_window (
		.enable(mem_en), // R13 R14
		.addr_field(host_req_addr[`MEM_ADDR_HI:`MEM_ADDR_LO]),
		.base(memory_window_base[`WIN_FIELD_HI:`WIN_FIELD_LO]),
		.limit(memory_window_limit[`WIN_FIELD_HI:`WIN_FIELD_LO]),
		.hit(mem_hit)
	);

	window_range_match #(
		.W(12)
	) u_pref_window (
		.enable(mem_en), // R13 R14
		.addr_field(host_req_addr[`MEM_ADDR_HI:`MEM_ADDR_LO]),
		.base(prefetch_window_base[`WIN_FIELD_HI:`WIN_FIELD_LO]),
		.limit(prefetch_window_limit[`WIN_FIELD_HI:`WIN_FIELD_LO]),
		.hit(pref_hit)
	);

	// the I/O window stays dark until software turns on the enable
	window_range_match #(
		.W(4)
	) u_io_window (
		.enable(io_en), // R15 R16
		.addr_field(host_req_addr[`IO_ADDR_HI:`IO_ADDR_LO]),
		.base(io_window_base[`IO_FIELD_HI:`IO_FIELD_LO]),
		.limit(io_window_limit[`IO_FIELD_HI:`IO_FIELD_LO]),
		.hit(io_hit)
	);

	wire mem_claim_next = host_req_valid & ~host_req_is_io & (mem_hit | pref_hit); // R13 R14
	wire io_claim_next = host_req_valid & host_req_is_io & io_hit; // R15

	// ==========================================================
	// secondary-side master cycles
	// without the enable the cycle is never claimed, so the master aborts
	wire accept_next = frame_req_valid & bm_en & frame_req_in_range; // R11
	wire abort_next = frame_req_valid & ~(bm_en & frame_req_in_range); // R10
	// sideband and pipe requests bypass the master enable entirely
	wire sba_next = sba_req_valid; // R12

	// ==========================================================
	// system-error messaging
	wire msg_valid;
	wire signaled;

	serr_reporter #(
		.NERR(NERR)
	) u_serr (
		.ref_clk(ref_clk),
		.rst(rst),
		.global_en(serr_en), // R3 R4
		.err_enable(bridge_control_reg), // R5
		.err_cond(err_condition),
		.link_ready(hub_link_ready),
		.msg_valid(msg_valid),
		.signaled(signaled)
	);

	// ==========================================================
	// activity counters
	// a count event in the same cycle as the clearing write survives as one
	always @* begin
		abort_count_next = abort_count_reg;
		serr_count_next = serr_count_reg;
		if (cfg_wr && act_sel) begin
			abort_count_next = `CNT_ZERO;
			serr_count_next = `CNT_ZERO;
		end
		if (frame_master_abort) begin
			if (cfg_wr && act_sel) begin
				abort_count_next = `CNT_ONE;
			end else begin
				abort_count_next = abort_count_reg + `CNT_ONE;
			end
		end
		if (signaled) begin
			if (cfg_wr && act_sel) begin
				serr_count_next = `CNT_ONE;
			end else begin
				serr_count_next = serr_count_reg + `CNT_ONE;
			end
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			abort_count_reg <= `CNT_ZERO;
			serr_count_reg <= `CNT_ZERO;
		end else begin
			abort_count_reg <= abort_count_next;
			serr_count_reg <= serr_count_next;
		end
	end

	// ==========================================================
	// read path
	// counters saturate never; they wrap, which software must allow for
	always @* begin
		rdata_next = `RD_ZERO;
		if (cfg_rd && cmd_sel) begin
			rdata_next = bridge_command_reg; // R1 R17
		end else if (cfg_rd && act_sel) begin
			rdata_next = {serr_count_reg, abort_count_reg};
		end
	end

	// ==========================================================
	// output registers
	always @(posedge ref_clk) begin
		if (rst) begin
			cfg_rdata <= `RD_ZERO;
			hub_link_serr_msg <= 1'b0;
			sys_err_signaled <= 1'b0;
			host_mem_claim <= 1'b0;
			host_io_claim <= 1'b0;
			frame_accept <= 1'b0;
			frame_master_abort <= 1'b0;
			sba_accept <= 1'b0;
			bus_master_enable <= 1'b0;
			memory_access_enable <= 1'b0;
			io_access_enable <= 1'b0;
			sys_err_msg_enable <= 1'b0;
		end else begin
			cfg_rdata <= rdata_next;
			hub_link_serr_msg <= msg_valid & serr_en; // R4
			sys_err_signaled <= signaled; // R5
			host_mem_claim <= mem_claim_next;
			host_io_claim <= io_claim_next;
			frame_accept <= accept_next;
			frame_master_abort <= abort_next; // R10
			sba_accept <= sba_next; // R12
			bus_master_enable <= bridge_command_next[`BIT_BM_EN];
			memory_access_enable <= bridge_command_next[`BIT_MEM_EN];
			io_access_enable <= bridge_command_next[`BIT_IO_EN];
			sys_err_msg_enable <= bridge_command_next[`BIT_SERR];
		end
	end

endmodule

// ===== rtl/serr_reporter.v
// system-error message request toward the hub link
`include "bridge_cmd_consts.vh"
module serr_reporter #(
	parameter NERR = 4
) (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// enables
	input wire global_en,
	input wire [NERR-1:0] err_enable,
	// error events, one-cycle pulses
	input wire [NERR-1:0] err_cond,
	// hub link handshake
	input wire link_ready,
	output reg msg_valid,
	output reg signaled
);

	// ==========================================================
	// per-condition gating
	wire [NERR-1:0] qual;
	genvar i;
	generate
		for (i = 0; i < NERR; i = i + 1) begin : g_qual
			assign qual[i] = err_cond[i] & err_enable[i];
		end
	endgenerate

	wire fire = global_en & (|qual);
	wire sent = msg_valid & link_ready;
	reg msg_next;

	// ==========================================================
	// pending message
	always @* begin
		msg_next = msg_valid;
		if (!global_en) begin
			msg_next = 1'b0;
		end else if (fire) begin
			msg_next = 1'b1;
		end else if (sent) begin
			msg_next = 1'b0;
		end
	end

	// a new error in the cycle the message leaves keeps the request up
	always @(posedge ref_clk) begin
		if (rst) begin
			msg_valid <= 1'b0;
			signaled <= 1'b0;
		end else begin
			msg_valid <= msg_next;
			signaled <= sent & global_en;
		end
	end

endmodule

// ===== rtl/window_range_match.v
// inclusive base/limit address window comparator
module window_range_match #(
	parameter W = 12
) (
	// qualifier
	input wire enable,
	// address field and window bounds
	input wire [W-1:0] addr_field,
	input wire [W-1:0] base,
	input wire [W-1:0] limit,
	// result
	output wire hit
);

	// ==========================================================
	// compare
	// a base above the limit gives an empty window, as the reset values intend
	assign hit = enable && (addr_field >= base) && (addr_field <= limit);

endmodule

// ===== tb/bridge_cmd_chk_sva.sv
// assertion checker for the bridge command register
module bridge_cmd_chk (
	// clock, reset, configuration port
	input logic ref_clk,
	input logic rst,
	input logic [7:0] cfg_addr,
	input logic cfg_rd,
	input logic [15:0] cfg_rdata,
	// cycles, answers and enables
	input logic frame_req_valid,
	input logic frame_req_in_range,
	input logic frame_accept,
	input logic frame_master_abort,
	input logic sba_req_valid,
	input logic sba_accept,
	input logic host_req_valid,
	input logic host_req_is_io,
	input logic host_mem_claim,
	input logic host_io_claim,
	input logic hub_link_serr_msg,
	input logic bus_master_enable,
	input logic memory_access_enable,
	input logic io_access_enable,
	input logic sys_err_msg_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	wire cr = cfg_rd && cfg_addr == 8'h04;
	// ==========================================================
	// properties
	property p_fixed; cr |=> (cfg_rdata & 16'hfef8) == 16'h0000; endproperty
	a_fixed: assert property (p_fixed) else $error("fixed bit set");
	property p_rbits; cr |=> cfg_rdata[8:0] == {sys_err_msg_enable, 5'h00,
		bus_master_enable, memory_access_enable, io_access_enable}; endproperty
	a_rbits: assert property (p_rbits) else $error("bits vs enables");
	property p_abort; frame_req_valid && !bus_master_enable |=>
		frame_master_abort && !frame_accept; endproperty
	a_abort: assert property (p_abort) else $error("no abort");
	property p_accept; frame_req_valid && bus_master_enable && frame_req_in_range |=>
		frame_accept && !frame_master_abort; endproperty
	a_accept: assert property (p_accept) else $error("no accept");
	property p_sba; sba_req_valid |=> sba_accept; endproperty
	a_sba: assert property (p_sba) else $error("sba dropped");
	property p_nomem; host_req_valid && !host_req_is_io && !memory_access_enable
		|=> !host_mem_claim; endproperty
	a_nomem: assert property (p_nomem) else $error("mem claim");
	property p_noio; host_req_valid && host_req_is_io && !io_access_enable
		|=> !host_io_claim; endproperty
	a_noio: assert property (p_noio) else $error("io claim");
	// one cycle of grace: clearing the enable drops a pending message on the next edge
	property p_nomsg; !sys_err_msg_enable && !$past(sys_err_msg_enable)
		|-> !hub_link_serr_msg; endproperty
	a_nomsg: assert property (p_nomsg) else $error("message while off");
	c_acc: cover property (frame_accept);
	c_mem: cover property (host_mem_claim);
	c_msg: cover property ($rose(hub_link_serr_msg));
endmodule
bind bridge_command_register bridge_cmd_chk i_chk (.ref_clk, .rst, .cfg_addr, .cfg_rd,
	.cfg_rdata, .frame_req_valid, .frame_req_in_range, .frame_accept, .frame_master_abort,
	.sba_req_valid, .sba_accept, .host_req_valid, .host_req_is_io, .host_mem_claim,
	.host_io_claim, .hub_link_serr_msg, .bus_master_enable, .memory_access_enable,
	.io_access_enable, .sys_err_msg_enable);

// ===== tb/test_bridge_command_register.sv
// self-checking bench for the bridge command register
module test_bridge_command_register;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// stimulus and model state
	logic ref_clk = '0, rst = '1, cfg_wr = '0, cfg_rd = '0, hub_link_ready = '0;
	logic host_req_valid = '0, host_req_is_io = '0, frame_req_valid = '0;
	logic frame_req_in_range = '0, sba_req_valid = '0;
	logic [7:0] cfg_addr = 8'h00, io_window_base = 8'h20, io_window_limit = 8'h30;
	logic [15:0] cfg_wdata = 16'h0000, memory_window_base = 16'h1000;
	logic [15:0] memory_window_limit = 16'h1ff0, prefetch_window_base = 16'h4000;
	logic [15:0] prefetch_window_limit = 16'h4ff0, lr = 16'h6b09, w;
	logic [3:0] bridge_control_reg = 4'h0, err_condition = 4'h0;
	logic [31:0] host_req_addr = 32'h0;
	logic [31:0] mt [4] = '{32'h1234_5678, 32'h4abc_0000, 32'h8000_0000, 32'h1fff_ffff};
	logic [31:0] it [4] = '{32'h2abc, 32'h3fff, 32'h5000, 32'h1fff};
	wire [15:0] cfg_rdata;
	wire hub_link_serr_msg, sys_err_signaled, host_mem_claim, host_io_claim, frame_accept;
	wire frame_master_abort, sba_accept, bus_master_enable, memory_access_enable;
	wire io_access_enable, sys_err_msg_enable;
	int n_fail = 0, samples_checked = 0, cmd_model = 0, n_abort = 0, i, x;
	bridge_command_register #(.NERR(4)) i_dut (.ref_clk, .rst, .cfg_addr, .cfg_wdata,
		.cfg_wr, .cfg_rd, .cfg_rdata, .memory_window_base, .memory_window_limit,
		.prefetch_window_base, .prefetch_window_limit, .io_window_base, .io_window_limit,
		.bridge_control_reg, .err_condition, .hub_link_ready, .hub_link_serr_msg,
		.sys_err_signaled, .host_req_valid, .host_req_addr, .host_req_is_io,
		.host_mem_claim, .host_io_claim, .frame_req_valid, .frame_req_in_range,
		.frame_accept, .frame_master_abort, .sba_req_valid, .sba_accept,
		.bus_master_enable, .memory_access_enable, .io_access_enable, .sys_err_msg_enable);
	always #12.5 ref_clk = ~ref_clk;
	// ==========================================================
	// helpers
	function logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function logic mhit(input logic [31:0] a);
		return (a[31:20] >= memory_window_base[15:4] && a[31:20] <= memory_window_limit[15:4])
			|| (a[31:20] >= prefetch_window_base[15:4] && a[31:20] <= prefetch_window_limit[15:4]);
	endfunction
	function logic ihit(input logic [31:0] a);
		return a[15:12] >= io_window_base[7:4] && a[15:12] <= io_window_limit[7:4];
	endfunction
	task final_report;
		if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one strobe cycle; read data is sampled in the cycle after it
	task acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
		if (wr && a == 8'h04) cmd_model = d & 16'h0107;
		@(posedge ref_clk);
		cfg_wr <= wr;
		cfg_rd <= !wr;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge ref_clk);
		cfg_wr <= '0;
		cfg_rd <= '0;
		#1;
	endtask
	task cyc(input logic fv, input logic fr, input logic hio, input logic [31:0] ha);
		@(posedge ref_clk);
		frame_req_valid <= fv;
		frame_req_in_range <= fr;
		sba_req_valid <= fv;
		host_req_valid <= '1;
		host_req_is_io <= hio;
		host_req_addr <= ha;
		@(posedge ref_clk);
		frame_req_valid <= '0;
		sba_req_valid <= '0;
		host_req_valid <= '0;
		#1;
	endtask
	// message is due two cycles after the error pulse
	task errp(input logic [3:0] e);
		@(posedge ref_clk);
		err_condition <= e;
		@(posedge ref_clk);
		err_condition <= 4'h0;
		@(posedge ref_clk);
		#1;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= '0;
		acc(0, 8'h04, 16'h0000);
		chk(cfg_rdata, 0);
		for (i = 0; i < 16; i++) begin
			if (i == 12) @(posedge ref_clk) memory_window_base <= 16'h1800;
			lr = nx(lr);
			x = ((i >> 2) ^ i) & 3;
			w = {lr[15:9], i[3], lr[7:3], i[2:0]};
			acc(1, 8'h04, w);
			chk({sys_err_msg_enable, bus_master_enable, memory_access_enable,
				io_access_enable}, {cmd_model[8], cmd_model[2:0]});
			acc(1, 8'h05, ~w);
			acc(0, 8'h05, 16'h0000);
			chk(cfg_rdata, 0);
			acc(0, 8'h04, 16'h0000);
			chk(cfg_rdata, cmd_model);
			cyc(1, lr[5], 0, mt[x]);
			chk(frame_accept, cmd_model[2] & lr[5]);
			chk(frame_master_abort, !(cmd_model[2] & lr[5]));
			n_abort += !(cmd_model[2] & lr[5]);
			chk(sba_accept, 1);
			chk(host_mem_claim, cmd_model[1] & mhit(host_req_addr));
			cyc(0, 0, 1, it[x]);
			chk(host_io_claim, cmd_model[0] & ihit(host_req_addr));
		end
		// activity word: message count high byte, master aborts low byte
		acc(0, 8'h80, 16'h0000);
		chk(cfg_rdata, n_abort);
		// reset in mid-run must bring back the all-zero command word
		@(posedge ref_clk) rst <= '1;
		repeat (2) @(posedge ref_clk);
		rst <= '0;
		cmd_model = 0;
		#1;
		chk({sys_err_msg_enable, bus_master_enable, memory_access_enable,
			io_access_enable}, 0);
		acc(0, 8'h04, 16'h0000);
		chk(cfg_rdata, cmd_model);
		acc(0, 8'h80, 16'h0000);
		chk(cfg_rdata, 0);
		@(posedge ref_clk) bridge_control_reg <= 4'h1;
		acc(1, 8'h04, 16'h0000);
		errp(4'h1);
		chk(hub_link_serr_msg, 0);
		acc(1, 8'h04, 16'h0100);
		errp(4'h2);
		chk(hub_link_serr_msg, 0);
		errp(4'h1);
		chk(hub_link_serr_msg, 1);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(hub_link_serr_msg, 1);
		@(posedge ref_clk);
		hub_link_ready <= '1;
		@(posedge ref_clk);
		hub_link_ready <= '0;
		@(posedge ref_clk);
		#1;
		chk(sys_err_signaled, 1);
		errp(4'h1);
		acc(1, 8'h04, 16'h0000);
		@(posedge ref_clk);
		#1;
		chk(hub_link_serr_msg, 0);
		// one message went out; the dropped one must not count
		acc(0, 8'h80, 16'h0000);
		chk(cfg_rdata, 16'h0100);
		acc(1, 8'h80, 16'hffff);
		acc(0, 8'h80, 16'h0000);
		chk(cfg_rdata, 16'h0000);
		final_report;
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		n_fail++;
		final_report;
	end
endmodule
